// [psr_bank.sv]
// top of the peripheral soft reset bank: register port, three words, reset outputs
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module psr_bank (
  // clock and reset
  input  wire logic                          ref_clk_i,
  input  wire logic                          reset_n_i,
  // register port
  input  wire logic [psr_pkg::ADDR_W-1:0]    reg_addr_i,
  input  wire logic [psr_pkg::DATA_W-1:0]    reg_wdata_i,
  input  wire logic                          reg_wr_i,
  input  wire logic                          reg_rd_i,
  output logic      [psr_pkg::DATA_W-1:0]    reg_rdata_o,
  // capability masks, same clock domain
  input  wire logic [psr_pkg::DATA_W-1:0]    capability_mask_word_one_i,
  input  wire logic [psr_pkg::DATA_W-1:0]    capability_mask_word_two_i,
  input  wire logic [psr_pkg::DATA_W-1:0]    capability_mask_word_four_i,
  // peripheral resets, active high
  output psr_pkg::psr_resets_t               periph_reset_o
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [psr_pkg::DATA_W-1:0] rdata;
    psr_pkg::psr_resets_t       resets;
  } psr_bank_state_t;

  psr_bank_state_t                  state_r;
  psr_bank_state_t                  state_nxt;
  psr_pkg::psr_req_t                req;
  logic [psr_pkg::DATA_W-1:0]       word_zero;
  logic [psr_pkg::DATA_W-1:0]       word_one;
  logic [psr_pkg::DATA_W-1:0]       word_two;
  logic                             sel_zero;
  logic                             sel_one;
  logic                             sel_two;

  // strobes that reached a mapped word
  logic                             wr_zero;
  logic                             wr_one;
  logic                             wr_two;
  logic                             rd_hit;

  // one named tap per peripheral reset, taken from the stored words
  logic                             can_controller_zero_reset;
  logic                             converter_zero_reset;
  logic                             hibernation_unit_reset;
  logic                             watchdog_unit_reset;
  logic                             comparator_one_reset;
  logic                             comparator_zero_reset;
  logic [psr_pkg::NUM_COUNTERS-1:0] gp_counter_reset;
  logic                             i2c_one_reset;
  logic                             i2c_zero_reset;
  logic                             sync_serial_one_reset;
  logic                             sync_serial_zero_reset;
  logic                             async_serial_one_reset;
  logic                             async_serial_zero_reset;
  logic [psr_pkg::NUM_PORTS-1:0]    io_port_reset;

  // readback words rebuilt from the taps
  logic [psr_pkg::DATA_W-1:0]       view_zero;
  logic [psr_pkg::DATA_W-1:0]       view_one;
  logic [psr_pkg::DATA_W-1:0]       view_two;
  logic [psr_pkg::DATA_W-1:0]       rd_sel;

  assign req      = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};
  assign sel_zero = (req.addr == psr_pkg::OFF_RESET_WORD_ZERO);
  assign sel_one  = (req.addr == psr_pkg::OFF_RESET_WORD_ONE);
  assign sel_two  = (req.addr == psr_pkg::OFF_RESET_WORD_TWO);

  // a strobe to an unmapped offset selects no word and is dropped here
  assign wr_zero  = req.wr && sel_zero;
  assign wr_one   = req.wr && sel_one;
  assign wr_two   = req.wr && sel_two;
  assign rd_hit   = req.rd && (sel_zero || sel_one || sel_two);

  ////////////////////////////////////////////////////////////////////////////
  psr_word #(
    .IMPL_MASK (psr_pkg::WORD_ZERO_IMPL),
    .RST_VAL   (psr_pkg::RESET_WORD_RST)
  ) u_word_zero (
    .ref_clk_i  (ref_clk_i),
    .reset_n_i  (reset_n_i),
    .wr_en_i    (wr_zero),
    .wdata_i    (req.wdata),
    .cap_mask_i (capability_mask_word_one_i),
    .value_o    (word_zero)
  );

  psr_word #(
    .IMPL_MASK (psr_pkg::WORD_ONE_IMPL),
    .RST_VAL   (psr_pkg::RESET_WORD_RST)
  ) u_word_one (
    .ref_clk_i  (ref_clk_i),
    .reset_n_i  (reset_n_i),
    .wr_en_i    (wr_one),
    .wdata_i    (req.wdata),
    .cap_mask_i (capability_mask_word_two_i),
    .value_o    (word_one)
  );

  psr_word #(
    .IMPL_MASK (psr_pkg::WORD_TWO_IMPL),
    .RST_VAL   (psr_pkg::RESET_WORD_RST)
  ) u_word_two (
    .ref_clk_i  (ref_clk_i),
    .reset_n_i  (reset_n_i),
    .wr_en_i    (wr_two),
    .wdata_i    (req.wdata),
    .cap_mask_i (capability_mask_word_four_i),
    .value_o    (word_two)
  );

  ////////////////////////////////////////////////////////////////////////////
  // one named tap per peripheral; the bit positions live in the package
  assign can_controller_zero_reset = word_zero[psr_pkg::BIT_CAN_ZERO];
  assign converter_zero_reset      = word_zero[psr_pkg::BIT_ADC0];
  assign hibernation_unit_reset    = word_zero[psr_pkg::BIT_HIBER];
  assign watchdog_unit_reset       = word_zero[psr_pkg::BIT_WDOG];
  assign comparator_one_reset      = word_one[psr_pkg::BIT_CMP_ONE];
  assign comparator_zero_reset     = word_one[psr_pkg::BIT_CMP_ZERO];
  assign gp_counter_reset          = word_one[psr_pkg::BIT_CNT_LO +: psr_pkg::NUM_COUNTERS];
  assign i2c_one_reset             = word_one[psr_pkg::BIT_I2C1];
  assign i2c_zero_reset            = word_one[psr_pkg::BIT_I2C0];
  assign sync_serial_one_reset     = word_one[psr_pkg::BIT_SYNC1];
  assign sync_serial_zero_reset    = word_one[psr_pkg::BIT_SYNC0];
  assign async_serial_one_reset    = word_one[psr_pkg::BIT_ASYNC1];
  assign async_serial_zero_reset   = word_one[psr_pkg::BIT_ASYNC0];
  assign io_port_reset             = word_two[psr_pkg::NUM_PORTS-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // readback rebuilt field by field, so a reserved bit can only read zero
  // even if a stored bit ever escaped the implemented mask
  always_comb
  begin
    view_zero                        = '0;
    view_zero[psr_pkg::BIT_CAN_ZERO] = can_controller_zero_reset;
    view_zero[psr_pkg::BIT_ADC0]     = converter_zero_reset;
    view_zero[psr_pkg::BIT_HIBER]    = hibernation_unit_reset;
    view_zero[psr_pkg::BIT_WDOG]     = watchdog_unit_reset;
  end

  always_comb
  begin
    view_one                         = '0;
    view_one[psr_pkg::BIT_CMP_ONE]   = comparator_one_reset;
    view_one[psr_pkg::BIT_CMP_ZERO]  = comparator_zero_reset;
    view_one[psr_pkg::BIT_CNT_LO +: psr_pkg::NUM_COUNTERS] = gp_counter_reset;
    view_one[psr_pkg::BIT_I2C1]      = i2c_one_reset;
    view_one[psr_pkg::BIT_I2C0]      = i2c_zero_reset;                  // bit between stays zero
    view_one[psr_pkg::BIT_SYNC1]     = sync_serial_one_reset;
    view_one[psr_pkg::BIT_SYNC0]     = sync_serial_zero_reset;
    view_one[psr_pkg::BIT_ASYNC1]    = async_serial_one_reset;
    view_one[psr_pkg::BIT_ASYNC0]    = async_serial_zero_reset;
  end

  always_comb
  begin
    view_two                         = '0;
    view_two[psr_pkg::NUM_PORTS-1:0] = io_port_reset;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read select; an unmapped offset falls through to zero
  always_comb
  begin
    rd_sel = '0;
    case (1'b1)
      sel_zero: rd_sel = view_zero;
      sel_one:  rd_sel = view_one;
      sel_two:  rd_sel = view_two;
      default:  rd_sel = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset outputs follow the stored words one cycle later, so they are flopped;
  // the extra cycle keeps the bus decode off the peripheral reset nets
  always_comb
  begin
    state_nxt                     = state_r;

    // word zero: system peripherals
    state_nxt.resets.can_zero     = can_controller_zero_reset;
    state_nxt.resets.adc0         = converter_zero_reset;
    state_nxt.resets.hiber        = hibernation_unit_reset;
    state_nxt.resets.wdog         = watchdog_unit_reset;

    // word one: analog, counters and serial units
    state_nxt.resets.comp         = {comparator_one_reset, comparator_zero_reset};
    state_nxt.resets.counter      = gp_counter_reset;
    state_nxt.resets.i2c          = {i2c_one_reset, i2c_zero_reset};
    state_nxt.resets.sync_serial  = {sync_serial_one_reset, sync_serial_zero_reset};
    state_nxt.resets.async_serial = {async_serial_one_reset, async_serial_zero_reset};

    // word two: io ports, port a in bit zero
    state_nxt.resets.io_port      = io_port_reset;

    // read data stands only the cycle after the strobe, zero otherwise
    state_nxt.rdata               = '0;
    if (rd_hit)
    begin
      state_nxt.rdata             = rd_sel;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end

  assign reg_rdata_o    = state_r.rdata;
  assign periph_reset_o = state_r.resets;

endmodule // psr_bank
`default_nettype wire

// [psr_bank_assertions.sv]
// port checker for the soft reset bank
`timescale 1ns/10ps
`default_nettype none
module psr_bank_chk (
  // clock and reset
  input wire logic                 ref_clk_i,
  input wire logic                 reset_n_i,
  // register port
  input wire logic [11:0]          reg_addr_i,
  input wire logic [31:0]          reg_wdata_i,
  input wire logic                 reg_wr_i,
  input wire logic                 reg_rd_i,
  input wire logic [31:0]          reg_rdata_o,
  // capability masks
  input wire logic [31:0]          capability_mask_word_one_i,
  input wire logic [31:0]          capability_mask_word_two_i,
  input wire logic [31:0]          capability_mask_word_four_i,
  // resets
  input wire psr_pkg::psr_resets_t periph_reset_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  rsvd_zero_a: assert property (reg_rd_i && reg_addr_i == 12'h040 |=> (reg_rdata_o & 32'hfefeffb7) == 32'h0)
    else $error("word zero reserved bits set");
  rsvd_one_a: assert property (reg_rd_i && reg_addr_i == 12'h044 |=> (reg_rdata_o & 32'hfcf0afcc) == 32'h0)
    else $error("word one reserved bits set");
  rsvd_two_a: assert property (reg_rd_i && reg_addr_i == 12'h048 |=> reg_rdata_o[31:8] == 24'h0)
    else $error("word two reserved bits set");
  out_cause_a: assert property ($changed(periph_reset_o) |-> $past(reg_wr_i, 2))
    else $error("reset outputs moved without a write");
  io_write_a: assert property (reg_wr_i && reg_addr_i == 12'h048 && capability_mask_word_four_i[7:0] == 8'hff
    |-> ##2 periph_reset_o.io_port == $past(reg_wdata_i[7:0], 2)) else $error("port resets wrong");
  io_keep_a: assert property (reg_wr_i && reg_addr_i == 12'h048 && capability_mask_word_four_i[7:0] == 8'h00
    |-> ##2 $stable(periph_reset_o.io_port)) else $error("masked port resets changed");
  can_write_a: assert property (reg_wr_i && reg_addr_i == 12'h040 && capability_mask_word_one_i[24]
    |-> ##2 periph_reset_o.can_zero == $past(reg_wdata_i[24], 2)) else $error("can reset wrong");
  cnt_write_a: assert property (reg_wr_i && reg_addr_i == 12'h044 && capability_mask_word_two_i[19:16] == 4'hf
    |-> ##2 periph_reset_o.counter == $past(reg_wdata_i[19:16], 2)) else $error("counter resets wrong");
endmodule // psr_bank_chk
bind psr_bank psr_bank_chk i_psr_bank_chk (.*);
`default_nettype wire

// [psr_pkg.sv]
// package for the peripheral soft reset bank: offsets, field layouts, reset values
`default_nettype none
package psr_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  localparam logic [ADDR_W-1:0] OFF_RESET_WORD_ZERO = 12'h040;
  localparam logic [ADDR_W-1:0] OFF_RESET_WORD_ONE  = 12'h044;
  localparam logic [ADDR_W-1:0] OFF_RESET_WORD_TWO  = 12'h048;

  localparam logic [DATA_W-1:0] RESET_WORD_RST = 32'h0000_0000;

  // writable bit sets; all other bits are reserved
  localparam logic [DATA_W-1:0] WORD_ZERO_IMPL = 32'h0101_0048;
  localparam logic [DATA_W-1:0] WORD_ONE_IMPL  = 32'h030f_5033;
  localparam logic [DATA_W-1:0] WORD_TWO_IMPL  = 32'h0000_00ff;

  // field positions
  localparam int unsigned BIT_CAN_ZERO = 24;
  localparam int unsigned BIT_ADC0     = 16;
  localparam int unsigned BIT_HIBER    = 6;
  localparam int unsigned BIT_WDOG     = 3;
  localparam int unsigned BIT_CMP_ONE  = 25;
  localparam int unsigned BIT_CMP_ZERO = 24;
  localparam int unsigned BIT_CNT_LO   = 16;
  localparam int unsigned BIT_I2C1     = 14;
  localparam int unsigned BIT_I2C0     = 12;
  localparam int unsigned BIT_SYNC1    = 5;
  localparam int unsigned BIT_SYNC0    = 4;
  localparam int unsigned BIT_ASYNC1   = 1;
  localparam int unsigned BIT_ASYNC0   = 0;
  localparam int unsigned NUM_COUNTERS = 4;
  localparam int unsigned NUM_PORTS    = 8;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } psr_req_t;

  typedef struct packed {
    logic                    can_zero;
    logic                    adc0;
    logic                    hiber;
    logic                    wdog;
    logic [1:0]              comp;
    logic [NUM_COUNTERS-1:0] counter;
    logic [1:0]              i2c;
    logic [1:0]              sync_serial;
    logic [1:0]              async_serial;
    logic [NUM_PORTS-1:0]    io_port;
  } psr_resets_t;

endpackage
`default_nettype wire

// [psr_word.sv]
// one masked software reset word: write gating, reserved bits, readback
`timescale 1ns/10ps
`default_nettype none
module psr_word #(
  parameter logic [31:0] IMPL_MASK = 32'hffff_ffff,
  parameter logic [31:0] RST_VAL   = 32'h0000_0000
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  // write side
  input  wire logic        wr_en_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [31:0] cap_mask_i,
  // state
  output logic      [31:0] value_o
);

  typedef struct packed {
    logic [31:0] word;
  } psr_word_state_t;

  psr_word_state_t state_r;
  psr_word_state_t state_nxt;
  logic [31:0]     wr_bits;

  always_comb
  begin
    state_nxt = state_r;
    wr_bits   = IMPL_MASK & cap_mask_i;
    if (wr_en_i)
    begin
      // only enabled bits change; others keep their value
      state_nxt.word = (state_r.word & ~wr_bits) | (wdata_i & wr_bits);
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      state_r <= '{word: RST_VAL};
    else
      state_r <= state_nxt;
  end

  assign value_o = state_r.word;

endmodule // psr_word
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the soft reset bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [11:0] addr = 12'h0, a;
  logic [31:0] wdata = 32'h0, cap1 = 32'h0, cap2 = 32'h0, cap4 = 32'h0, rdata, d, c, lfsr, m [3];
  psr_pkg::psr_resets_t res;
  int err_count = 0, tests_run = 0, cyc = 0;
  localparam logic [11:0] OFF [3] = '{12'h040, 12'h044, 12'h048};
  localparam logic [31:0] IMP [3] = '{psr_pkg::WORD_ZERO_IMPL, psr_pkg::WORD_ONE_IMPL, psr_pkg::WORD_TWO_IMPL};
  psr_bank i_psr_bank (.ref_clk_i(clk), .reset_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .capability_mask_word_one_i(cap1), .capability_mask_word_two_i(cap2),
    .capability_mask_word_four_i(cap4), .periph_reset_o(res));
  initial
  begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      complete_run();
    end
  end
  function automatic logic [31:0] lf(input logic [31:0] s);
    lf = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // rotated per word so a mask taken from the wrong word shows up
  function automatic logic [31:0] capv(input int k, input logic [31:0] v);
    capv = (k == 0) ? v : (k == 1) ? {v[15:0], v[31:16]} : {v[7:0], v[31:8]};
  endfunction
  function automatic logic [31:0] rdm(input logic [11:0] x);
    rdm = 32'h0;
    for (int k = 0; k < 3; k++)
      if (x == OFF[k])
        rdm = m[k];
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wrt(input logic [11:0] x, input logic [31:0] v, input logic [31:0] k4);
    @(posedge clk);
    addr <= x;
    wdata <= v;
    wr <= 1'b1;
    cap1 <= capv(0, k4);
    cap2 <= capv(1, k4);
    cap4 <= capv(2, k4);
    @(posedge clk);
    wr <= 1'b0;
    for (int k = 0; k < 3; k++)
      if (x == OFF[k])
        m[k] = (m[k] & ~(IMP[k] & capv(k, k4))) | (v & IMP[k] & capv(k, k4));
    @(posedge clk);
    #1 chk("resets", {8'h00, res}, {8'h00, m[0][24], m[0][16], m[0][6], m[0][3], m[1][25:24], m[1][19:16],
      m[1][14], m[1][12], m[1][5:4], m[1][1:0], m[2][7:0]});
  endtask
  task automatic rdc(input logic [11:0] x);
    @(posedge clk);
    addr <= x;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", rdata, rdm(x));
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    m = '{default: 32'h0};
    lfsr = 32'h0000003e;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      rdc(OFF[k]);
      wrt(OFF[k], 32'hffffffff, 32'hffffffff);
      rdc(OFF[k]);
      wrt(OFF[k], 32'h0, 32'h0);
      rdc(OFF[k]);
    end
    for (int i = 0; i < 200; i++)
    begin
      lfsr = lf(lf(lf(lfsr)));
      d = lf(lfsr);
      c = (i % 4 == 0) ? 32'hffffffff : (i % 4 == 1) ? 32'h0 : lf(d);
      a = (lfsr[1:0] == 2'h3) ? 12'h04c : OFF[lfsr[1:0]];
      wrt(a, d, c);
      rdc(a);
    end
    // read-modify-write: flip the implemented bits, carry reserved bits as read
    for (int k = 0; k < 3; k++)
    begin
      rdc(OFF[k]);
      d = rdata;
      wrt(OFF[k], d ^ IMP[k], 32'hffffffff);
      rdc(OFF[k]);
    end
    @(posedge clk);
    rst_n <= 1'b0;
    m = '{default: 32'h0};
    @(posedge clk);
    #1 chk("reset", {8'h00, res}, 32'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 3; k++)
      rdc(OFF[k]);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
